// file: core/otcc_regs.svh
// Constants for the OLED timing/config command slice.
// Assumes inclusion by bare name from the core and bench files.
`ifndef OTCC_REGS_SVH
`define OTCC_REGS_SVH
`define OTCC_OP_CLKDIV      8'hD5
`define OTCC_OP_PRECHG      8'hD9
`define OTCC_OP_PADCFG      8'hDA
`define OTCC_OP_DESEL       8'hDB
`define OTCC_OP_RMW         8'hE0
`define OTCC_OP_END         8'hEE
`define OTCC_OP_COL_LO      4'h0
`define OTCC_OP_COL_HI      4'h1
`define OTCC_POR_DIV        4'h0
`define OTCC_POR_TRIM       4'h5
`define OTCC_POR_PRE        4'h2
`define OTCC_POR_DIS        4'h2
`define OTCC_POR_ALT        1'b1
`define OTCC_POR_DESEL      8'h35
`define OTCC_POR_COL        8'h00
`define OTCC_PAD_BIT        4
`define OTCC_DESEL_SAT      8'h40
`define OTCC_BETA_BASE      16'h01AE
`define OTCC_BETA_STEP      21'h0190F
`define OTCC_BETA_HALF      21'h001F4
`define OTCC_BETA_SCALE     21'h003E8
`define OTCC_BETA_ONE       16'h03E8
`define OTCC_COM_HALF       6'h20
`endif

// file: core/otcc_pkg.sv
// Types for the OLED timing/config command slice.
// Assumes otcc_regs.svh is on the include path.
package otcc_pkg;
	// Host byte as seen after synchronisation
	typedef struct packed {
		logic       commandDataSelect;
		logic [7:0] data;
	} otcc_byte_t;
	// Settings held by the command decoder
	typedef struct packed {
		logic [3:0] divCode;
		logic [3:0] oscTrim;
		logic [3:0] preLen;
		logic [3:0] disLen;
		logic       altLayout;
		logic [7:0] commonDeselectLevel;
	} otcc_cfg_t;
	typedef enum logic [1:0] {
		OTCC_PH_IDLE,
		OTCC_PH_DIS,
		OTCC_PH_PRE
	} otcc_phase_t;
	typedef enum logic [2:0] {
		OTCC_EXP_OPCODE,
		OTCC_EXP_CLKDIV,
		OTCC_EXP_PRECHG,
		OTCC_EXP_PADCFG,
		OTCC_EXP_DESEL
	} otcc_exp_t;
endpackage

// file: core/otcc_core.sv
// Command decoder for clock divide, phase lengths, pad layout, deselect level
// and read-modify-write column handling, plus the display clock and phases.
// Assumes host strobes arrive asynchronously and are one-byte-per-strobe.
`timescale 1ns/10ps
`include "otcc_regs.svh"
module otcc_core (
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic             hostWrStrobe,
	input  wire logic             hostRdStrobe,
	input  wire logic             commandDataSelect,
	input  wire logic [7:0]       hostData,
	input  wire logic [3:0]       rowClocks,
	output otcc_pkg::otcc_cfg_t   cfg,
	output logic                  divided_display_tick,
	output otcc_pkg::otcc_phase_t phase,
	output logic                  rowDone,
	output logic [7:0]            columnAddr,
	output logic                  rmwActive,
	output logic [9:0]            deselectBeta,
	output logic                  segmentSideEven
);
	// Two-stage synchronisers for pins
	logic [10:0] sync1Q;
	logic [10:0] sync2Q;
	logic        wrPrevQ;
	logic        rdPrevQ;
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1Q  <= 11'h000;
			sync2Q  <= 11'h000;
			wrPrevQ <= 1'b0;
			rdPrevQ <= 1'b0;
		end
		else
		begin
			sync1Q  <= {hostWrStrobe, hostRdStrobe, commandDataSelect, hostData};
			sync2Q  <= sync1Q;
			wrPrevQ <= sync2Q[10];
			rdPrevQ <= sync2Q[9];
		end
	end

	otcc_pkg::otcc_byte_t inByte;
	logic                 wrEvt;
	logic                 rdEvt;
	assign inByte = otcc_pkg::otcc_byte_t'(sync2Q[8:0]);
	assign wrEvt  = sync2Q[10] & ~wrPrevQ;
	assign rdEvt  = sync2Q[9] & ~rdPrevQ;

	// Deselect factor in thousandths, step in millionths, rounded to nearest
	function automatic logic [9:0] betaOf(input logic [7:0] code);
		logic [20:0] prod;
		prod = 21'(code) * `OTCC_BETA_STEP + `OTCC_BETA_HALF;
		if (code >= `OTCC_DESEL_SAT)
			betaOf = 10'(`OTCC_BETA_ONE);
		else
			betaOf = 10'(`OTCC_BETA_BASE) + 10'(prod / `OTCC_BETA_SCALE);
	endfunction

	// Decoder state
	otcc_pkg::otcc_exp_t expQ, expD;
	otcc_pkg::otcc_cfg_t cfgQ, cfgD;
	logic [7:0] colQ, colD, savedQ, savedD;
	logic       rmwQ, rmwD;
	always_comb
	begin
		expD   = expQ;
		cfgD   = cfgQ;
		colD   = colQ;
		savedD = savedQ;
		rmwD   = rmwQ;
		if (wrEvt && !inByte.commandDataSelect)
		begin
			case (expQ)
				otcc_pkg::OTCC_EXP_CLKDIV:
				begin
					cfgD.divCode = inByte.data[3:0];
					cfgD.oscTrim = inByte.data[7:4];
					expD = otcc_pkg::OTCC_EXP_OPCODE;
				end
				otcc_pkg::OTCC_EXP_PRECHG:
				begin
					cfgD.preLen = inByte.data[3:0];
					cfgD.disLen = inByte.data[7:4];
					expD = otcc_pkg::OTCC_EXP_OPCODE;
				end
				otcc_pkg::OTCC_EXP_PADCFG:
				begin
					cfgD.altLayout = inByte.data[`OTCC_PAD_BIT];
					expD = otcc_pkg::OTCC_EXP_OPCODE;
				end
				otcc_pkg::OTCC_EXP_DESEL:
				begin
					cfgD.commonDeselectLevel = inByte.data;
					expD = otcc_pkg::OTCC_EXP_OPCODE;
				end
				default:
				begin
					case (inByte.data)
						`OTCC_OP_CLKDIV: expD = otcc_pkg::OTCC_EXP_CLKDIV;
						`OTCC_OP_PRECHG: expD = otcc_pkg::OTCC_EXP_PRECHG;
						`OTCC_OP_PADCFG: expD = otcc_pkg::OTCC_EXP_PADCFG;
						`OTCC_OP_DESEL:  expD = otcc_pkg::OTCC_EXP_DESEL;
						`OTCC_OP_RMW:
						begin
							if (!rmwQ)
								savedD = colQ;
							rmwD = 1'b1;
						end
						`OTCC_OP_END:
						begin
							if (rmwQ)
								colD = savedQ;
							rmwD = 1'b0;
						end
						default:
						begin
							if (inByte.data[7:4] == `OTCC_OP_COL_LO)
								colD = {colQ[7:4], inByte.data[3:0]};
							else if (inByte.data[7:4] == `OTCC_OP_COL_HI)
								colD = {inByte.data[3:0], colQ[3:0]};
						end
					endcase
				end
			endcase
		end
		else if (wrEvt && inByte.commandDataSelect)
		begin
			colD = colQ + 8'h01;
		end
		else if (rdEvt && inByte.commandDataSelect && !rmwQ)
		begin
			colD = colQ + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			expQ   <= otcc_pkg::OTCC_EXP_OPCODE;
			cfgQ   <= {`OTCC_POR_DIV, `OTCC_POR_TRIM, `OTCC_POR_PRE, `OTCC_POR_DIS,
				`OTCC_POR_ALT, `OTCC_POR_DESEL};
			colQ   <= `OTCC_POR_COL;
			savedQ <= `OTCC_POR_COL;
			rmwQ   <= 1'b0;
		end
		else
		begin
			expQ   <= expD;
			cfgQ   <= cfgD;
			colQ   <= colD;
			savedQ <= savedD;
			rmwQ   <= rmwD;
		end
	end

	// Display tick divider and phase sequencer
	logic [3:0]            divCntQ, divCntD;
	logic                  tickQ, tickD;
	otcc_pkg::otcc_phase_t phQ, phD;
	logic [3:0]            phCntQ, phCntD;
	logic                  rowQ, rowD;
	always_comb
	begin
		divCntD = divCntQ;
		tickD   = 1'b0;
		phD     = phQ;
		phCntD  = phCntQ;
		rowD    = 1'b0;
		if (divCntQ >= cfgQ.divCode)
		begin
			divCntD = 4'h0;
			tickD   = 1'b1;
		end
		else
			divCntD = divCntQ + 4'h1;
		if (tickQ)
		begin
			case (phQ)
				otcc_pkg::OTCC_PH_DIS:
				begin
					if (phCntQ + 4'h1 >= cfgQ.disLen)
					begin
						phD    = otcc_pkg::OTCC_PH_PRE;
						phCntD = 4'h0;
					end
					else
						phCntD = phCntQ + 4'h1;
				end
				otcc_pkg::OTCC_PH_PRE:
				begin
					if (phCntQ + 4'h1 >= cfgQ.preLen)
					begin
						phD    = otcc_pkg::OTCC_PH_IDLE;
						phCntD = 4'h0;
					end
					else
						phCntD = phCntQ + 4'h1;
				end
				default:
				begin
					// remaining row clocks then next row
					if (phCntQ + 4'h1 >= rowClocks)
					begin
						phD    = otcc_pkg::OTCC_PH_DIS;
						phCntD = 4'h0;
						rowD   = 1'b1;
					end
					else
						phCntD = phCntQ + 4'h1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			divCntQ <= 4'h0;
			tickQ   <= 1'b0;
			phQ     <= otcc_pkg::OTCC_PH_DIS;
			phCntQ  <= 4'h0;
			rowQ    <= 1'b0;
		end
		else
		begin
			divCntQ <= divCntD;
			tickQ   <= tickD;
			phQ     <= phD;
			phCntQ  <= phCntD;
			rowQ    <= rowD;
		end
	end

	// Registered derived outputs
	logic [9:0] betaQ;
	logic       evenQ;
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			betaQ <= 10'h000;
			evenQ <= 1'b1;
		end
		else
		begin
			betaQ <= betaOf(cfgQ.commonDeselectLevel);
			evenQ <= cfgQ.altLayout;
		end
	end

	assign cfg                  = cfgQ;
	assign divided_display_tick = tickQ;
	assign phase                = phQ;
	assign rowDone              = rowQ;
	assign columnAddr           = colQ;
	assign rmwActive            = rmwQ;
	assign deselectBeta         = betaQ;
	assign segmentSideEven      = evenQ;

	// Checks
	a_rmw_read_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(rmwQ && rdEvt && inByte.commandDataSelect && !wrEvt) |=> $stable(colQ))
		else $error("column moved on read in rmw mode");
	a_end_restores: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(rmwQ && wrEvt && !inByte.commandDataSelect && inByte.data == `OTCC_OP_END
		&& expQ == otcc_pkg::OTCC_EXP_OPCODE) |=> (colQ == $past(savedQ) && !rmwQ))
		else $error("end did not restore column");
	a_write_advance: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wrEvt && inByte.commandDataSelect) |=> colQ == $past(colQ) + 8'h01)
		else $error("data write did not advance column");
	a_param_taken: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wrEvt && !inByte.commandDataSelect && expQ == otcc_pkg::OTCC_EXP_DESEL)
		|=> (cfgQ.commonDeselectLevel == $past(inByte.data) && !$changed(rmwQ)))
		else $error("parameter byte not taken");
	a_div_take: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wrEvt && !inByte.commandDataSelect && expQ == otcc_pkg::OTCC_EXP_CLKDIV)
		|=> cfgQ.divCode == $past(inByte.data[3:0]))
		else $error("divide code not stored");
	a_trim_take: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wrEvt && !inByte.commandDataSelect && expQ == otcc_pkg::OTCC_EXP_CLKDIV)
		|=> cfgQ.oscTrim == $past(inByte.data[7:4]))
		else $error("trim not stored");
	a_phase_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(tickQ && phQ == otcc_pkg::OTCC_PH_PRE && phCntQ + 4'h1 >= cfgQ.preLen)
		|=> phQ == otcc_pkg::OTCC_PH_IDLE)
		else $error("pre-charge overran");
	a_dis_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(tickQ && phQ == otcc_pkg::OTCC_PH_DIS && phCntQ + 4'h1 >= cfgQ.disLen)
		|=> phQ == otcc_pkg::OTCC_PH_PRE)
		else $error("dis-charge overran");
	a_layout_take: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wrEvt && !inByte.commandDataSelect && expQ == otcc_pkg::OTCC_EXP_PADCFG)
		|=> ##1 evenQ == $past(inByte.data[`OTCC_PAD_BIT], 2))
		else $error("layout bit not applied");
	a_phase_tick: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!tickQ |=> $stable(phQ))
		else $error("phase moved without tick");
	a_beta_sat: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cfgQ.commonDeselectLevel >= `OTCC_DESEL_SAT) |=> betaQ == 10'h3E8)
		else $error("deselect factor not saturated");
endmodule

// file: sim/otcc_host_model.sv
// Host processor model that writes and reads bytes on the parallel port.
// Assumes ref_clk at 100 MHz; the bench calls put and put2.
`timescale 1ns/10ps
module otcc_host_model (
	input  wire logic ref_clk,
	output logic      hostWrStrobe,
	output logic      hostRdStrobe,
	output logic      commandDataSelect,
	output logic [7:0] hostData
);
	// Idle port at time zero
	initial
	begin
		hostWrStrobe = 1'b0;
		hostRdStrobe = 1'b0;
		commandDataSelect = 1'b0;
		hostData = 8'hFF;
	end
	// One strobe: setup, high and low each three clocks
	task automatic put(input logic sel, input logic rd, input logic [7:0] val);
		@(negedge ref_clk);
		commandDataSelect = sel;
		hostData = val;
		repeat (3) @(negedge ref_clk);
		hostRdStrobe = rd;
		hostWrStrobe = !rd;
		repeat (3) @(negedge ref_clk);
		hostRdStrobe = 1'b0;
		hostWrStrobe = 1'b0;
		@(negedge ref_clk);
		// Hold over, so the bus no longer shows the byte
		hostData = ~val;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic put2(input logic [7:0] op, input logic [7:0] prm);
		put(1'b0, 1'b0, op);
		put(1'b0, 1'b0, prm);
	endtask
endmodule

// file: sim/oled_timing_config_cmds_bench.sv
// Self-checking bench for the command decoder, compared with an integer model.
// Assumes otcc_regs.svh on the include path and otcc_pkg compiled first.
`timescale 1ns/10ps
`include "otcc_regs.svh"
module oled_timing_config_cmds_bench;
	logic                  ref_clk;
	logic                  rst_b;
	logic [3:0]            rowClocks;
	logic                  hostWrStrobe;
	logic                  hostRdStrobe;
	logic                  commandDataSelect;
	logic [7:0]            hostData;
	otcc_pkg::otcc_cfg_t   cfg;
	otcc_pkg::otcc_phase_t phase;
	logic                  tick;
	logic                  rowDone;
	logic [7:0]            columnAddr;
	logic                  rmwActive;
	logic [9:0]            deselectBeta;
	logic                  segmentSideEven;
	int                    badCount;
	int                    nChecks;
	int                    seed;
	int                    div, trim, pre, dis, alt, desel, col, saved, rmw;
	otcc_core u_otcc_core (.ref_clk(ref_clk), .rst_b(rst_b), .hostWrStrobe(hostWrStrobe),
		.hostRdStrobe(hostRdStrobe), .commandDataSelect(commandDataSelect),
		.hostData(hostData), .rowClocks(rowClocks), .cfg(cfg),
		.divided_display_tick(tick), .phase(phase), .rowDone(rowDone),
		.columnAddr(columnAddr), .rmwActive(rmwActive), .deselectBeta(deselectBeta),
		.segmentSideEven(segmentSideEven));
	otcc_host_model u_otcc_host_model (.ref_clk(ref_clk), .hostWrStrobe(hostWrStrobe),
		.hostRdStrobe(hostRdStrobe), .commandDataSelect(commandDataSelect),
		.hostData(hostData));
	// Clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Basic compare
	task automatic chk(input string what, input int exp, input logic [15:0] got);
		nChecks++;
		if (got !== exp[15:0])
		begin
			badCount++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// Compare settings and column against the model
	task automatic chkState;
		chk("divCode", div, 16'(cfg.divCode));
		chk("oscTrim", trim, 16'(cfg.oscTrim));
		chk("preLen", pre, 16'(cfg.preLen));
		chk("disLen", dis, 16'(cfg.disLen));
		chk("altLayout", alt, 16'(cfg.altLayout));
		chk("sideEven", alt, 16'(segmentSideEven));
		chk("deselCode", desel, 16'(cfg.commonDeselectLevel));
		chk("columnAddr", col, 16'(columnAddr));
		chk("rmwActive", rmw, 16'(rmwActive));
		chk("beta", desel >= 64 ? 1000 : (430000 + desel * 6415 + 500) / 1000,
			16'(deselectBeta));
	endtask
	// Tick period, row length, phase at row end and pre-charge span in clocks
	task automatic chkTiming;
		int n;
		int k;
		for (k = 0; k < 2; k++)
			do @(negedge ref_clk); while (tick !== 1'b1);
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (tick !== 1'b1);
		chk("tickPeriod", div + 1, 16'(n));
		for (k = 0; k < 2; k++)
			do @(negedge ref_clk); while (rowDone !== 1'b1);
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (rowDone !== 1'b1);
		chk("rowPeriod", (div + 1) * (dis + pre + (rowClocks ? rowClocks : 1)), 16'(n));
		chk("phaseAtRow", int'(otcc_pkg::OTCC_PH_DIS), 16'(phase));
		do @(negedge ref_clk); while (phase !== otcc_pkg::OTCC_PH_PRE);
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (phase === otcc_pkg::OTCC_PH_PRE);
		chk("preSpan", pre * (div + 1), 16'(n));
	endtask
	// Single command byte, model follows
	task automatic cmd(input logic [7:0] op);
		u_otcc_host_model.put(1'b0, 1'b0, op);
		if (op[7:4] == 4'h0)
			col = (col & 8'hF0) | op[3:0];
		if (op[7:4] == 4'h1)
			col = (col & 8'h0F) | (op[3:0] << 4);
		if (op == `OTCC_OP_RMW && !rmw)
		begin
			rmw = 1;
			saved = col;
		end
		if (op == `OTCC_OP_END && rmw)
		begin
			rmw = 0;
			col = saved;
		end
	endtask
	// Two-byte command, model follows
	task automatic cmd2(input logic [7:0] op, input logic [7:0] prm);
		u_otcc_host_model.put2(op, prm);
		case (op)
			`OTCC_OP_CLKDIV: {trim, div} = {28'h0, prm[7:4], 28'h0, prm[3:0]};
			`OTCC_OP_PRECHG: {dis, pre} = {28'h0, prm[7:4], 28'h0, prm[3:0]};
			`OTCC_OP_PADCFG: alt = prm[4];
			default: desel = prm;
		endcase
	endtask
	// Display data byte; reads hold the column in the mode
	task automatic dat(input logic rd);
		u_otcc_host_model.put(1'b1, rd, 8'($random(seed)));
		if (!rd)
			col = (col + 1) & 8'hFF;
	endtask
	// Closing verdict
	task automatic wrapUp;
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#500000;
		badCount++;
		wrapUp;
	end
	// Main sequence
	initial
	begin
		logic [7:0] p;
		int i;
		seed = 30806;
		badCount = 0;
		nChecks = 0;
		rst_b = 1'b0;
		rowClocks = 4'h3;
		{div, trim, pre, dis, alt, desel, col, rmw} = {32'h0, 32'h5, 32'h2, 32'h2,
			32'h1, 32'h35, 32'h0, 32'h0};
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (2) @(negedge ref_clk);
		chkState;
		chkTiming;
		for (i = 0; i < 6; i++)
		begin
			@(negedge ref_clk);
			rowClocks = 4'($random(seed));
			cmd2(`OTCC_OP_CLKDIV, 8'($random(seed)));
			p = 8'($random(seed));
			p[3:0] = p[3:0] ? p[3:0] : 4'h1;
			p[7:4] = p[7:4] ? p[7:4] : 4'hF;
			cmd2(`OTCC_OP_PRECHG, p);
			cmd2(`OTCC_OP_PADCFG, i[0] ? 8'h12 : 8'h02);
			p = 8'($random(seed) & 8'h3F);
			// saturated codes, then codes below saturation, then zero
			cmd2(`OTCC_OP_DESEL, i < 3 ? 8'h40 + p : (i < 5 ? p : 8'h00));
			chkState;
			chkTiming;
		end
		// Parameter equal to an opcode, then a lone column byte
		cmd2(`OTCC_OP_CLKDIV, `OTCC_OP_PADCFG);
		cmd(8'h02);
		cmd2(`OTCC_OP_DESEL, 8'h35);
		chkState;
		// mode entered twice, closed by one end command, then an end outside the mode
		cmd(8'h05);
		cmd(8'h1F);
		dat(1'b0);
		cmd(`OTCC_OP_RMW);
		for (i = 0; i < 4; i++)
			dat(i[1]);
		chkState;
		cmd(`OTCC_OP_RMW);
		dat(1'b0);
		cmd(`OTCC_OP_END);
		chkState;
		cmd(`OTCC_OP_END);
		dat(1'b0);
		chkState;
		wrapUp;
	end
endmodule
